//--- pbs_pkg.sv
// Shared constants and carrier types for the pipelined burst memory port
package pbs_pkg;

  // Array geometry
  localparam int ADDR_W    = 17;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int MEM_DEPTH = 131072;

  // Burst and pipeline shape
  localparam int BURST_LEN  = 4;
  localparam int PIPE_DEPTH = 2;
  localparam int BUF_DEPTH  = 2;

  // Clock figures
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DATA_LATENCY_PS = PIPE_DEPTH * CLK_PERIOD_PS;
  localparam int DATA_LATENCY_CYC = (DATA_LATENCY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Reset values and the burst counter step
  localparam logic [LANES-1:0]  BE_NONE    = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
  localparam logic [1:0]        CNT_RESET  = 2'h0;
  localparam logic [1:0]        CNT_STEP   = 2'h1;

  // Burst state
  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_READ,
    BURST_WRITE
  } pbs_burst_e;

  // One pipeline slot: an access in flight
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be_n;
  } pbs_op_s;

  // One read-buffer entry
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } pbs_rd_s;

  localparam pbs_op_s OP_IDLE = '{valid: 1'b0, write: 1'b0, addr: '0, be_n: BE_NONE};
  localparam pbs_rd_s RD_IDLE = '{valid: 1'b0, data: DATA_RESET};

endpackage

//--- pbs_skid_buf.sv
// Two-entry read-data buffer with valid/ready on both sides
`timescale 1ns/10ps
module pbs_skid_buf (
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  // Fill side
  input  wire logic            in_valid_i,
  output logic                 in_ready_o,
  input  wire pbs_pkg::pbs_rd_s in_data_i,
  // Drain side
  output logic                 out_valid_o,
  input  wire logic            out_ready_i,
  output pbs_pkg::pbs_rd_s     out_data_o
);
  import pbs_pkg::*;

  pbs_rd_s    entry [BUF_DEPTH];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // Full refuses a push even when a pop is due, so ready never depends on the drain
  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = entry[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      entry[0] <= RD_IDLE;
      entry[1] <= RD_IDLE;
    end else if (push) begin
      entry[wr_ptr] <= in_data_i;
    end
  end

endmodule

//--- pbs_sram_port.sv
// Pipelined burst static memory port with two-cycle data latency
// Functional notes
// - Address register loads on load, clock enabled and all chip selects true.
// - Selected load starts a new access with fresh address and control.
// - Load while deselected ends any burst in progress.
// - Advance steps the burst counter and ignores the address inputs.
// - Read/write at load picks the access; data moves two cycles later.
// - Clock enable high freezes everything but the test port as if the edge never came.
// - Each nine-bit lane has its own active-low write enable.
// - Byte enables are ignored when read/write is high at load and on read-burst advances; write-burst advances use them.
// - Enabled lanes are written two cycles after the write command.
// - Load with any chip select false starts a deselect cycle.
// - Data bus floats two cycles after a deselect cycle starts.
// - Active-high chip select counts like the low ones, inverted.
// - All timing is on the rising clock edge except output enable.
// - Data output path is registered; data input feeds the memory write and forwarding directly.
// - Burst order select high gives interleaved, low gives linear order.
// - Output enable high floats the data pins at once.
// - Test port samples mode select and data in on test clock rise.
// - Test port drives its output from test clock fall.
// - One loaded address gives a data cycle on every advance until the next load or deselect, wrapping within four words.
`timescale 1ns/10ps
module pbs_sram_port (
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // Command inputs
  input  wire logic [pbs_pkg::ADDR_W-1:0]   address_inputs_i,
  input  wire logic                         advance_or_load_i,
  input  wire logic                         read_write_i,
  input  wire logic                         clock_enable_n_i,
  input  wire logic [pbs_pkg::LANES-1:0]    byte_write_enables_n_i,
  input  wire logic                         chip_select_n_first_i,
  input  wire logic                         chip_select_high_i,
  input  wire logic                         chip_select_n_second_i,
  input  wire logic                         burst_order_select_i,
  input  wire logic                         output_enable_n_i,
  // Data pins
  input  wire logic [pbs_pkg::DATA_W-1:0]   data_pins_i,
  output logic      [pbs_pkg::DATA_W-1:0]   data_pins_o,
  output logic                              data_pins_oe_o,
  // Test access port
  input  wire logic                         tck_i,
  input  wire logic                         tms_i,
  input  wire logic                         tdi_i,
  output logic                              tdo_o,
  output logic                              tdo_oe_o
);
  import pbs_pkg::*;

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  pbs_op_s           cmd_q;
  pbs_op_s           exe_q;
  pbs_op_s           next_cmd;
  pbs_burst_e        burst_q;
  pbs_burst_e        next_burst;
  logic [1:0]        cnt_q;
  logic [1:0]        next_cnt;
  logic [1:0]        base_lo_q;
  logic [ADDR_W-1:2] base_hi_q;
  logic              order_q;
  logic              chip_sel;
  logic              load_sel;
  logic              load_desel;
  logic              advance;
  logic              buf_in_ready;
  logic              buf_out_valid;
  pbs_rd_s           buf_in;
  pbs_rd_s           buf_out;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] mem_old;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_word;
  logic [LANES-1:0]  fwd_hit;
  logic              drive_q;
  logic              tck_prev;
  logic              tms_q;
  logic              bypass_q;
  logic              tck_rise;
  logic              tck_fall;

  assign chip_sel   = ~chip_select_n_first_i & chip_select_high_i & ~chip_select_n_second_i;
  assign load_sel   = ~advance_or_load_i & chip_sel;
  assign load_desel = ~advance_or_load_i & ~chip_sel;
  assign advance    = ~clock_enable_n_i & buf_in_ready;

  always_comb begin
    next_cmd   = OP_IDLE;
    next_burst = burst_q;
    next_cnt   = cnt_q;
    if (load_sel) begin
      next_cmd.valid = 1'b1;
      next_cmd.write = ~read_write_i;
      next_cmd.addr  = address_inputs_i;
      next_cmd.be_n  = read_write_i ? BE_NONE : byte_write_enables_n_i;
      next_burst     = read_write_i ? BURST_READ : BURST_WRITE;
      next_cnt       = CNT_RESET;
    end else if (load_desel) begin
      next_burst = BURST_IDLE;
    end else begin
      case (burst_q)
        BURST_READ, BURST_WRITE: begin
          next_cnt       = 2'(cnt_q + CNT_STEP);
          next_cmd.valid = 1'b1;
          next_cmd.write = (burst_q == BURST_WRITE);
          next_cmd.addr  = {base_hi_q, order_q ? (base_lo_q ^ next_cnt)
                                               : 2'(base_lo_q + next_cnt)};
          next_cmd.be_n  = (burst_q == BURST_WRITE) ? byte_write_enables_n_i : BE_NONE;
        end
        BURST_IDLE: begin
          next_burst = BURST_IDLE;
        end
        default: begin
          next_burst = BURST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      burst_q   <= BURST_IDLE;
      cnt_q     <= CNT_RESET;
      base_lo_q <= 2'h0;
      base_hi_q <= '0;
      order_q   <= 1'b0;
    end else if (advance) begin
      burst_q <= next_burst;
      cnt_q   <= next_cnt;
      if (load_sel) begin
        base_lo_q <= address_inputs_i[1:0];
        base_hi_q <= address_inputs_i[ADDR_W-1:2];
        // order fixed per burst, sampled from the select at load
        order_q   <= burst_order_select_i;
      end
    end
  end

  // pipeline moves only on enabled edges
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_q <= OP_IDLE;
      exe_q <= OP_IDLE;
    end else if (advance) begin
      cmd_q <= next_cmd;
      exe_q <= cmd_q;
    end
  end

  assign mem_rd  = mem[cmd_q.addr];
  assign mem_old = mem[exe_q.addr];

  // per-lane merge and write-to-read forwarding
  // Forwarding covers a read issued one cycle after a write to the same word
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign fwd_hit[k] = exe_q.valid & exe_q.write & ~exe_q.be_n[k] &
                        (exe_q.addr == cmd_q.addr);
    assign wr_word[k*LANE_W +: LANE_W] = exe_q.be_n[k] ? mem_old[k*LANE_W +: LANE_W]
                                                       : data_pins_i[k*LANE_W +: LANE_W];
    assign rd_word[k*LANE_W +: LANE_W] = fwd_hit[k] ? data_pins_i[k*LANE_W +: LANE_W]
                                                    : mem_rd[k*LANE_W +: LANE_W];
  end

  // write lands two cycles after command
  always_ff @(posedge ref_clk_i) begin
    if (!rst_i && advance && exe_q.valid && exe_q.write) begin
      mem[exe_q.addr] <= wr_word;
    end
  end

  assign buf_in = {cmd_q.valid & ~cmd_q.write, rd_word};

  pbs_skid_buf pbs_skid_buf_inst (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (advance),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_out_valid),
    .out_ready_i (advance),
    .out_data_o  (buf_out)
  );

  // bus released when no read is due
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_pins_o <= DATA_RESET;
      drive_q     <= 1'b0;
    end else if (advance) begin
      if (buf_out_valid) begin
        data_pins_o <= buf_out.data;
        drive_q     <= buf_out.valid;
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // asynchronous output enable
  // The enable must act without a clock, so it is the one gated output
  assign data_pins_oe_o = drive_q & ~output_enable_n_i;

  assign tck_rise = tck_i & ~tck_prev;
  assign tck_fall = ~tck_i & tck_prev;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tck_prev <= 1'b0;
      tms_q    <= 1'b1;
      bypass_q <= 1'b0;
    end else begin
      tck_prev <= tck_i;
      if (tck_rise) begin
        tms_q    <= tms_i;
        bypass_q <= tdi_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o    <= bypass_q;
      tdo_oe_o <= ~tms_q;
    end
  end

  property p_load_capture;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_sel && advance) |=> (cmd_q.valid && cmd_q.addr == $past(address_inputs_i));
  endproperty
  a_load_capture: assert property (p_load_capture) else $error("load not captured");

  property p_desel;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_desel && advance) |=> (!cmd_q.valid && burst_q == BURST_IDLE);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect did not end burst");

  property p_load_ctl;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_sel && advance) |=> (cmd_q.write == !$past(read_write_i) && cnt_q == CNT_RESET &&
                               burst_q != BURST_IDLE);
  endproperty
  a_load_ctl: assert property (p_load_ctl) else $error("load did not start access");

  property p_read_be;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_sel && advance && read_write_i) |=> (cmd_q.be_n == BE_NONE);
  endproperty
  a_read_be: assert property (p_read_be) else $error("read kept byte enables");

  property p_advance;
    @(posedge ref_clk_i) disable iff (rst_i)
    (advance && advance_or_load_i && burst_q != BURST_IDLE)
      |=> (cnt_q == 2'($past(cnt_q) + CNT_STEP) && cmd_q.addr[ADDR_W-1:2] == base_hi_q);
  endproperty
  a_advance: assert property (p_advance) else $error("burst did not advance");

  property p_suspend;
    @(posedge ref_clk_i) disable iff (rst_i)
    clock_enable_n_i |=> ($stable(cmd_q) && $stable(exe_q) && $stable(data_pins_o) &&
                          $stable(drive_q));
  endproperty
  a_suspend: assert property (p_suspend) else $error("state moved while suspended");

  property p_read_lat;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_sel && read_write_i && !clock_enable_n_i) ##1 !clock_enable_n_i
      ##1 !clock_enable_n_i |=> drive_q;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data not driven");

  property p_float;
    @(posedge ref_clk_i) disable iff (rst_i)
    (load_desel && !clock_enable_n_i) ##1 !clock_enable_n_i ##1 !clock_enable_n_i
      |=> !drive_q;
  endproperty
  a_float: assert property (p_float) else $error("bus not released");

  property p_write_lane;
    @(posedge ref_clk_i) disable iff (rst_i)
    (advance && exe_q.valid && exe_q.write && !exe_q.be_n[0])
      |=> mem[$past(exe_q.addr)][LANE_W-1:0] == $past(data_pins_i[LANE_W-1:0]);
  endproperty
  a_write_lane: assert property (p_write_lane) else $error("lane not written");

  property p_oe;
    @(posedge ref_clk_i) disable iff (rst_i)
    output_enable_n_i |-> !data_pins_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("pins driven with enable high");

  property p_interleave;
    @(posedge ref_clk_i) disable iff (rst_i)
    (advance && advance_or_load_i && burst_q != BURST_IDLE && order_q)
      |=> cmd_q.addr[1:0] == (base_lo_q ^ cnt_q);
  endproperty
  a_interleave: assert property (p_interleave) else $error("bad interleave");

  property p_linear;
    @(posedge ref_clk_i) disable iff (rst_i)
    (advance && advance_or_load_i && burst_q != BURST_IDLE && !order_q)
      |=> cmd_q.addr[1:0] == 2'(base_lo_q + cnt_q);
  endproperty
  a_linear: assert property (p_linear) else $error("bad linear step");

  property p_tdo;
    @(posedge ref_clk_i) disable iff (rst_i)
    tck_fall |=> tdo_o == $past(bypass_q);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test output not updated");

  c_read:    cover property (@(posedge ref_clk_i) disable iff (rst_i) drive_q && data_pins_oe_o);
  c_write:   cover property (@(posedge ref_clk_i) disable iff (rst_i)
                             advance && exe_q.valid && exe_q.write);
  c_burst:   cover property (@(posedge ref_clk_i) disable iff (rst_i)
                             burst_q != BURST_IDLE && cnt_q == 2'h3);
  c_suspend: cover property (@(posedge ref_clk_i) disable iff (rst_i)
                             clock_enable_n_i && cmd_q.valid);

endmodule

//--- pbs_ctl_model.sv
// Behavioural memory controller driving the port's commands and write data
`timescale 1ns/10ps
module pbs_ctl_model (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // Command outputs
  output logic [pbs_pkg::ADDR_W-1:0] addr_o,
  output logic                       adv_o,
  output logic                       rw_o,
  output logic                       cen_n_o,
  output logic [pbs_pkg::LANES-1:0]  be_n_o,
  output logic [2:0]                 sel_o,
  // Write data
  output logic [pbs_pkg::DATA_W-1:0] wdata_o
);
  import pbs_pkg::*;
  logic [DATA_W:0] cur;
  logic [DATA_W:0] slot0;
  logic [DATA_W:0] slot1;
  initial begin
    addr_o = '0;
    adv_o = 1'b1;
    rw_o = 1'b1;
    cen_n_o = 1'b0;
    be_n_o = BE_NONE;
    sel_o = 3'b110;
    cur = '0;
    wdata_o = '0;
  end
  // enables set on every write cycle
  task automatic drive(input logic adv, input logic rw, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] be, input logic [DATA_W:0] d,
                       input logic [2:0] sel, input logic clock_enable_n);
    @(negedge ref_clk_i);
    adv_o = adv;
    rw_o = rw;
    addr_o = a;
    be_n_o = be;
    cur = d;
    sel_o = sel;
    cen_n_o = clock_enable_n;
  endtask
  // data follows two enabled edges after its command
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot0 <= '0;
      slot1 <= '0;
    end else if (!cen_n_o) begin
      slot0 <= cur;
      slot1 <= slot0;
    end
  end
  // Released bus shows the inverse of its previous value, so it alternates on every falling edge
  always @(negedge ref_clk_i) begin
    wdata_o <= slot1[DATA_W] ? slot1[DATA_W-1:0] : ~wdata_o;
  end
endmodule

//--- pbs_sram_port_test.sv
// Self-checking bench for the pipelined burst memory port
`timescale 1ns/10ps
module pbs_sram_port_test;
  import pbs_pkg::*;
  localparam logic [12:0] HI  = 13'h12a5;
  localparam logic [2:0]  SEL = 3'b010;
  localparam logic [2:0]  DESEL [3] = '{3'b110, 3'b000, 3'b011};
  logic              ref_clk_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic              adv, rw, cen_n;
  logic [LANES-1:0]  be_n;
  logic [2:0]        sel;
  logic [DATA_W-1:0] din, dout, exv;
  logic              doe, cen_s, tdo, tdo_oe;
  logic              order = 1'b0;
  logic              oe_n  = 1'b0;
  logic              tck   = 1'b0;
  logic              tms   = 1'b0;
  logic              tdi   = 1'b0;
  logic [DATA_W-1:0] shd [0:15];
  logic [DATA_W-1:0] exq [$];
  logic              act = 1'b0;
  logic              bwr = 1'b0;
  logic [3:0]        base = 4'h0;
  logic [1:0]        cnt = CNT_RESET;
  int                error_cnt = 0;
  int                compares = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  pbs_sram_port pbs_sram_port_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .address_inputs_i(addr), .advance_or_load_i(adv), .read_write_i(rw),
    .clock_enable_n_i(cen_n), .byte_write_enables_n_i(be_n),
    .chip_select_n_first_i(sel[2]), .chip_select_high_i(sel[1]),
    .chip_select_n_second_i(sel[0]), .burst_order_select_i(order),
    .output_enable_n_i(oe_n), .data_pins_i(din), .data_pins_o(dout),
    .data_pins_oe_o(doe), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe));
  pbs_ctl_model pbs_ctl_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_o(addr),
    .adv_o(adv), .rw_o(rw), .cen_n_o(cen_n), .be_n_o(be_n), .sel_o(sel), .wdata_o(din));

  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$urandom(), $urandom()});
  endfunction
  // Drives one cycle and notes what it must produce
  task automatic go(input logic a_adv, input logic a_rw, input logic [3:0] lo,
                    input logic [3:0] be, input logic [DATA_W-1:0] d,
                    input logic [2:0] s, input logic c);
    logic [3:0] ad;
    logic dv;
    ad = lo;
    dv = 1'b0;
    if (!c) begin
      if (!a_adv && s == SEL) begin
        act = 1'b1;
        bwr = !a_rw;
        base = lo;
        cnt = CNT_RESET;
      end else if (!a_adv) act = 1'b0;
      else if (act) cnt = cnt + CNT_STEP;
      if (act) begin
        ad = {base[3:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
        dv = bwr;
        if (!bwr) exq.push_back(shd[ad]);
        for (int k = 0; k < LANES; k++)
          if (bwr && !be[k]) shd[ad][k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
      end
    end
    pbs_ctl_model_inst.drive(a_adv, a_rw, {a_adv ? ~HI : HI, lo}, be, {dv, d}, s, c);
  endtask
  task automatic idle(input int n);
    repeat (n) go(1'b0, 1'b1, 4'h0, BE_NONE, '0, 3'b110, 1'b0);
  endtask
  task automatic tap(input logic v);
    tdi = v;
    tms = ~v;
    repeat (3) @(negedge ref_clk_i);
    tck = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk(tdo === ~v, "test output moved on rise");
    tck = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(tdo === v && tdo_oe === v, "test output after fall");
  endtask

  // Each enabled edge with the bus driven hands out the oldest read
  always @(posedge ref_clk_i) begin
    cen_s = cen_n;
    #1;
    if (!rst_i && cen_s === 1'b0 && doe === 1'b1) begin
      if (exq.size() == 0) begin
        chk(1'b0, "unexpected drive");
      end else begin
        exv = exq.pop_front();
        chk(dout === exv, "read data");
      end
    end
  end
  initial begin
    #50000;
    chk(1'b0, "run limit reached");
    end_sim();
  end

  initial begin
    void'($urandom(51302));
    repeat (5) @(negedge ref_clk_i);
    chk(doe === 1'b0 && tdo === 1'b0, "reset outputs");
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) go(1'b0, 1'b0, i[3:0], 4'h0, rnd(), SEL, 1'b0);
    // Read, byte write, forwarded reads back to back
    go(1'b0, 1'b1, 4'h1, 4'h0, '0, SEL, 1'b0);
    go(1'b0, 1'b0, 4'h1, 4'ha, rnd(), SEL, 1'b0);
    go(1'b0, 1'b1, 4'h1, 4'h0, '0, SEL, 1'b0);
    go(1'b0, 1'b0, 4'h9, 4'h3, rnd(), SEL, 1'b0);
    for (int k = 0; k < 3; k++) go(1'b1, 1'b0, 4'h0, k[3:0] + 4'h4, rnd(), SEL, 1'b0);
    go(1'b0, 1'b1, 4'h8, 4'h0, '0, SEL, 1'b0);
    repeat (4) go(1'b1, 1'b1, 4'h0, 4'h0, '0, SEL, 1'b0);
    // Each false select blocks a write; burst cut off by deselect
    for (int j = 0; j < 3; j++) begin
      go(1'b0, 1'b0, 4'h0, 4'h0, rnd(), DESEL[j], 1'b0);
      go(1'b0, 1'b1, 4'h0, 4'h0, '0, SEL, 1'b0);
    end
    go(1'b1, 1'b1, 4'h0, 4'h0, '0, SEL, 1'b0);
    idle(1);
    go(1'b1, 1'b1, 4'h0, 4'h0, '0, SEL, 1'b0);
    // Suspended edges freeze reads and drop writes
    go(1'b0, 1'b1, 4'h3, 4'h0, '0, SEL, 1'b0);
    go(1'b0, 1'b0, 4'h3, 4'h0, rnd(), SEL, 1'b1);
    go(1'b0, 1'b1, 4'h3, 4'h0, '0, SEL, 1'b1);
    go(1'b0, 1'b1, 4'h3, 4'h0, '0, SEL, 1'b0);
    idle(2);
    go(1'b0, 1'b1, 4'h7, 4'h0, '0, SEL, 1'b1);
    oe_n = 1'b1;
    #1 chk(doe === 1'b0, "output enable float");
    oe_n = 1'b0;
    #1 chk(doe === 1'b1, "output enable drive");
    idle(3);
    tap(1'b1);
    tap(1'b0);
    for (int o = 0; o < 2; o++) begin
      rst_i = 1'b1;
      // order only changes while held in reset
      order = o[0];
      act = 1'b0;
      repeat (5) @(negedge ref_clk_i);
      rst_i = 1'b0;
      go(1'b0, 1'b1, 4'h6, 4'h0, '0, SEL, 1'b0);
      repeat (5) go(1'b1, 1'b1, 4'h0, 4'h0, '0, SEL, 1'b0);
      repeat (300) go($urandom_range(3) != 0, 1'($urandom_range(1)), 4'($urandom_range(15)),
        4'($urandom_range(15)), rnd(), $urandom_range(7) == 0 ? 3'b000 : SEL,
        $urandom_range(7) == 0);
      idle(4);
    end
    chk(exq.size() == 0, "reads never returned");
    end_sim();
  end
endmodule
